/* hw/acso_top.sv */
// Notes on behaviour
// - Eight-channel chain: upper pins become serial inputs
// - Four-channel chain: dedicated input, output on lane a
// - Chain readback shifts one bit per bit-clock rise
// - Upstream data forwarded toward the host end
// - Format pins choose one or two lanes
// - Single lane uses one chain input only
// - Async start pin yields clock-aligned sync out
// - Serial-mode sync command also yields sync out
// - Sync input captured on master clock rise
// - Channel word: 8-bit header, 24-bit result
// - CRC only in serial mode, via select field
// - Per-channel CRC replaces header every 4/16
// - Sync presets all CRC accumulators to ones
// - Non-last samples of group carry status header
// - Last sample carries CRC over whole group
// - Accumulator preset to ones after CRC emitted
// - CRC headers on all channels at once
// - CRC-8 polynomial x^8 + x^2 + x + 1
// - Data enters CRC most significant bit first
// - Frame-ready fall starts frame, header first
`timescale 1ns/10ps
`default_nettype none
module acso_top (
  input  wire logic                  clock,                // Master clock
  input  wire logic                  rst_b,                // Async reset, active low
  input  wire logic                  data_bit_clock,       // Serial link bit clock
  input  wire logic                  sample_valid,         // New conversion set, pulse
  input  wire acso_pkg::acso_sample_t sample,              // Results and status headers
  input  wire logic                  serial_control_mode,  // Serial control port in use
  input  wire logic [1:0]            crc_select,           // CRC group select field
  input  wire logic                  sync_command,         // Sync command pulse
  input  wire logic                  start_n,              // Async start pin, active low
  input  wire logic                  sync_in_n,            // Sync input pin, active low
  input  wire logic                  four_channel_variant, // Strap: four-channel part
  input  wire logic                  chain_enable,         // Strap: chained operation
  input  wire logic [1:0]            output_format_select, // Strap: lane format
  input  wire logic [2:0]            chain_upstream_count, // Strap: devices upstream
  input  wire logic                  chain_in_dedicated,   // Chain input, four-channel part
  input  wire logic                  chain_in_lane_a_i,    // Chain pin a, input side
  input  wire logic                  chain_in_lane_b_i,    // Chain pin b, input side
  output logic                       sync_out_n,           // Aligned sync out, active low
  output logic                       frame_overrun,        // Set arrived while busy, pulse
  output logic                       frame_ready_n,        // Frame marker, active low
  output logic                       serial_out_lane_a,    // Serial data lane a
  output logic                       serial_out_lane_b,    // Serial data lane b
  output logic                       chain_in_lane_a_o,    // Chain pin a, output side
  output logic                       chain_in_lane_a_oe,   // Chain pin a drive enable
  output logic                       chain_in_lane_b_o,    // Chain pin b, output side
  output logic                       chain_in_lane_b_oe    // Chain pin b drive enable
);
  function automatic logic [7:0] crc_step24(input logic [7:0] acc, input logic [23:0] d);
    logic [7:0] c;
    logic       fb;
    c = acc;
    for (int i = 23; i >= 0; i--)
    begin
      fb = d[i] ^ c[7];
      c  = {c[6:0], 1'b0} ^ (fb ? acso_pkg::CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  function automatic logic lane_single(input acso_pkg::acso_strap_t s);
    if (s.four_variant)
    begin
      return s.format[0] | s.chain_enable;
    end
    return s.format[1];
  endfunction

  // Master clock domain
  logic                                start_meta_reg, start_sync_reg, start_prev_reg;
  logic                                sin_meta_reg, sin_sync_reg, sin_prev_reg;
  logic [3:0]                          sync_cnt_reg, sync_cnt_next;
  logic                                sync_out_n_reg;
  logic [3:0]                          group_cnt_reg, group_cnt_next;
  logic [7:0][7:0]                     crc_acc_reg, crc_acc_next;
  logic [7:0][7:0]                     crc_new;
  logic [7:0][31:0]                    staged_reg;
  logic [7:0][31:0]                    staged_next;
  logic                                req_reg, ack_meta_reg, ack_sync_reg, ack_reg;
  logic                                overrun_reg;
  wire logic                           start_fall = start_prev_reg & ~start_sync_reg;
  wire logic                           sync_req =
    start_fall | (sync_command & serial_control_mode);
  wire logic                           sync_event = sin_prev_reg & ~sin_sync_reg;
  wire logic                           crc_on = serial_control_mode &
    ((crc_select == acso_pkg::CRC_SEL_SHORT) | (crc_select == acso_pkg::CRC_SEL_LONG));
  wire logic [3:0]                     group_last = (crc_select == acso_pkg::CRC_SEL_LONG) ?
    acso_pkg::GROUP_LAST_LONG : acso_pkg::GROUP_LAST_SHORT;
  wire logic [3:0]                     group_base = sync_event ? 4'h0 : group_cnt_reg;
  wire logic                           group_end = (group_base == group_last);
  wire logic                           busy = req_reg ^ ack_sync_reg;
  wire logic                           take_set = sample_valid & ~busy;

  assign sync_cnt_next = sync_req ? acso_pkg::SYNC_OUT_CYCLES :
    ((sync_cnt_reg != 4'h0) ? 4'(sync_cnt_reg - 4'h1) : 4'h0);
  assign group_cnt_next = sample_valid ? (group_end ? 4'h0 : 4'(group_base + 4'h1)) :
    group_base;

  genvar g;
  generate
    for (g = 0; g < acso_pkg::CH_COUNT; g++)
    begin : g_ch
      wire logic [7:0] acc_base = sync_event ? acso_pkg::CRC_PRESET : crc_acc_reg[g];
      wire logic       emit_crc = crc_on & group_end;
      assign crc_new[g] = crc_step24(acc_base, sample.data[g]);
      assign crc_acc_next[g] = !sample_valid ? acc_base :
        (group_end ? acso_pkg::CRC_PRESET : crc_new[g]);
      assign staged_next[g] = {(emit_crc ? crc_new[g] : sample.status[g]),
                               sample.data[g]};
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      start_meta_reg <= 1'b1;
      start_sync_reg <= 1'b1;
      start_prev_reg <= 1'b1;
      sin_meta_reg   <= 1'b1;
      sin_sync_reg   <= 1'b1;
      sin_prev_reg   <= 1'b1;
    end
    else
    begin
      start_meta_reg <= start_n;
      start_sync_reg <= start_meta_reg;
      start_prev_reg <= start_sync_reg;
      sin_meta_reg   <= sync_in_n;
      sin_sync_reg   <= sin_meta_reg;
      sin_prev_reg   <= sin_sync_reg;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync_cnt_reg   <= 4'h0;
      sync_out_n_reg <= 1'b1;
      group_cnt_reg  <= 4'h0;
      crc_acc_reg    <= {8{acso_pkg::CRC_PRESET}};
      overrun_reg    <= 1'b0;
    end
    else
    begin
      sync_cnt_reg   <= sync_cnt_next;
      sync_out_n_reg <= (sync_cnt_next == 4'h0);
      group_cnt_reg  <= group_cnt_next;
      crc_acc_reg    <= crc_acc_next;
      overrun_reg    <= sample_valid & busy;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      staged_reg   <= '0;
      req_reg      <= 1'b0;
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
    end
    else
    begin
      ack_meta_reg <= ack_reg;
      ack_sync_reg <= ack_meta_reg;
      if (take_set)
      begin
        staged_reg <= staged_next;
        req_reg    <= ~req_reg;
      end
    end
  end

  // Link clock domain; staged words stay still while a request is open
  logic                                lrst_meta_reg, lrst_b_reg;
  logic                                req_meta_reg, req_sync_reg;
  acso_pkg::acso_strap_t               strap_meta_reg, strap_sync_reg, cfg_reg;
  acso_pkg::acso_link_state_t          state_reg;
  logic [acso_pkg::WCNT_W-1:0]         word_cnt_reg;
  logic [4:0]                          bit_cnt_reg;
  logic [31:0]                         shift_a_reg, shift_b_reg, in_a_reg, in_b_reg;
  logic                                frame_ready_n_reg, pin_oe_reg;
  logic [31:0]                         mem_a_rdata, mem_b_rdata;
  wire acso_pkg::acso_strap_t          strap_now = '{four_variant: four_channel_variant,
    chain_enable: chain_enable, format: output_format_select, upstream: chain_upstream_count};
  wire logic                           single = lane_single(cfg_reg);
  wire logic [3:0]                     words = cfg_reg.four_variant ?
    (single ? acso_pkg::WORDS_FOUR_SINGLE : acso_pkg::WORDS_FOUR_DUAL) :
    (single ? acso_pkg::WORDS_EIGHT_SINGLE : acso_pkg::WORDS_EIGHT_DUAL);
  wire logic [2:0]                     mask = 3'(words - 4'h1);
  wire logic [3:0]                     ups = cfg_reg.chain_enable ? {1'b0, cfg_reg.upstream} : 4'h0;
  wire logic [7:0]                     total_words = 8'(words * (ups + 4'h1));
  wire logic [6:0]                     last_word = 7'(total_words - 8'h01);
  wire logic [6:0]                     next_word = 7'(word_cnt_reg + 7'h01);
  wire logic                           next_own = ({3'h0, words} > next_word);
  wire logic [2:0]                     slot = word_cnt_reg[2:0] & mask;
  wire logic [2:0]                     read_slot = next_word[2:0] & mask;
  wire logic                           chain_a_bit = cfg_reg.four_variant ?
    chain_in_dedicated : chain_in_lane_a_i;
  wire logic                           chain_b_bit = ~cfg_reg.four_variant & ~single &
    chain_in_lane_b_i;
  wire logic                           word_end = (state_reg == acso_pkg::L_SHIFT) &
    (bit_cnt_reg == acso_pkg::BIT_LAST);
  wire logic                           frame_end = word_end & (word_cnt_reg == last_word);
  wire logic                           mem_we = word_end & cfg_reg.chain_enable;
  wire logic [31:0]                    load_a = next_own ? staged_reg[next_word[2:0]] :
    mem_a_rdata;
  wire logic [31:0]                    load_b = single ? 32'h0000_0000 :
    (next_own ? staged_reg[3'(words[2:0] + next_word[2:0])] : mem_b_rdata);
  wire logic                           pending = req_sync_reg ^ ack_reg;

  always_ff @(posedge data_bit_clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lrst_meta_reg <= 1'b0;
      lrst_b_reg    <= 1'b0;
    end
    else
    begin
      lrst_meta_reg <= 1'b1;
      lrst_b_reg    <= lrst_meta_reg;
    end
  end

  always_ff @(posedge data_bit_clock or negedge lrst_b_reg)
  begin
    if (!lrst_b_reg)
    begin
      req_meta_reg   <= 1'b0;
      req_sync_reg   <= 1'b0;
      strap_meta_reg <= '0;
      strap_sync_reg <= '0;
      pin_oe_reg     <= 1'b0;
    end
    else
    begin
      req_meta_reg   <= req_reg;
      req_sync_reg   <= req_meta_reg;
      strap_meta_reg <= strap_now;
      strap_sync_reg <= strap_meta_reg;
      pin_oe_reg     <= ~strap_sync_reg.four_variant & ~strap_sync_reg.chain_enable;
    end
  end

  always_ff @(posedge data_bit_clock or negedge lrst_b_reg)
  begin
    if (!lrst_b_reg)
    begin
      state_reg         <= acso_pkg::L_IDLE;
      cfg_reg           <= '0;
      ack_reg           <= 1'b0;
      word_cnt_reg      <= 7'h00;
      bit_cnt_reg       <= 5'h00;
      shift_a_reg       <= 32'h0000_0000;
      shift_b_reg       <= 32'h0000_0000;
      in_a_reg          <= 32'h0000_0000;
      in_b_reg          <= 32'h0000_0000;
      frame_ready_n_reg <= 1'b1;
    end
    else
    begin
      unique case (state_reg)
        acso_pkg::L_IDLE:
        begin
          if (pending)
          begin
            cfg_reg           <= strap_sync_reg;
            word_cnt_reg      <= 7'h00;
            frame_ready_n_reg <= 1'b0;
            state_reg         <= acso_pkg::L_MARK;
          end
        end
        acso_pkg::L_MARK:
        begin
          frame_ready_n_reg <= 1'b1;
          bit_cnt_reg       <= 5'h00;
          shift_a_reg       <= staged_reg[0];
          shift_b_reg       <= single ? 32'h0000_0000 : staged_reg[words[2:0]];
          state_reg         <= acso_pkg::L_SHIFT;
        end
        acso_pkg::L_SHIFT:
        begin
          in_a_reg    <= {in_a_reg[30:0], chain_a_bit};
          in_b_reg    <= {in_b_reg[30:0], chain_b_bit};
          bit_cnt_reg <= 5'(bit_cnt_reg + 5'h01);
          if (frame_end)
          begin
            shift_a_reg <= 32'h0000_0000;
            shift_b_reg <= 32'h0000_0000;
            ack_reg     <= req_sync_reg;
            state_reg   <= acso_pkg::L_IDLE;
          end
          else if (word_end)
          begin
            shift_a_reg  <= load_a;
            shift_b_reg  <= load_b;
            word_cnt_reg <= next_word;
          end
          else
          begin
            shift_a_reg <= {shift_a_reg[30:0], 1'b0};
            shift_b_reg <= {shift_b_reg[30:0], 1'b0};
          end
        end
      endcase
    end
  end

  acso_lane_mem u_mem_a (
    .clock      (data_bit_clock),
    .rst_b      (lrst_b_reg),
    .write_en   (mem_we),
    .write_addr (slot),
    .write_data ({in_a_reg[30:0], chain_a_bit}),
    .read_addr  (read_slot),
    .read_data  (mem_a_rdata)
  );

  acso_lane_mem u_mem_b (
    .clock      (data_bit_clock),
    .rst_b      (lrst_b_reg),
    .write_en   (mem_we & ~single),
    .write_addr (slot),
    .write_data ({in_b_reg[30:0], chain_b_bit}),
    .read_addr  (read_slot),
    .read_data  (mem_b_rdata)
  );

  assign sync_out_n         = sync_out_n_reg;
  assign frame_overrun      = overrun_reg;
  assign frame_ready_n      = frame_ready_n_reg;
  assign serial_out_lane_a  = shift_a_reg[31];
  assign serial_out_lane_b  = shift_b_reg[31];
  assign chain_in_lane_a_o  = 1'b0;
  assign chain_in_lane_b_o  = 1'b0;
  assign chain_in_lane_a_oe = pin_oe_reg;
  assign chain_in_lane_b_oe = pin_oe_reg;
endmodule
`default_nettype wire

/* shared/acso_pkg.sv */
`default_nettype none
package acso_pkg;
  localparam int unsigned CH_COUNT = 8;
  localparam int unsigned HDR_W    = 8;
  localparam int unsigned DATA_W   = 24;
  localparam int unsigned WORD_W   = 32;
  localparam int unsigned MEM_DEPTH = 8;
  localparam int unsigned MEM_AW   = 3;
  localparam int unsigned WCNT_W   = 7;

  localparam logic [7:0] CRC_PRESET       = 8'hFF;
  localparam logic [7:0] CRC_POLY         = 8'h07;
  localparam logic [1:0] CRC_SEL_SHORT    = 2'h1;
  localparam logic [1:0] CRC_SEL_LONG     = 2'h2;
  localparam logic [3:0] GROUP_LAST_SHORT = 4'h3;
  localparam logic [3:0] GROUP_LAST_LONG  = 4'hF;
  localparam logic [3:0] SYNC_OUT_CYCLES  = 4'h2;
  localparam logic [4:0] BIT_LAST         = 5'h1F;

  localparam logic [3:0] WORDS_EIGHT_DUAL   = 4'h4;
  localparam logic [3:0] WORDS_EIGHT_SINGLE = 4'h8;
  localparam logic [3:0] WORDS_FOUR_DUAL    = 4'h2;
  localparam logic [3:0] WORDS_FOUR_SINGLE  = 4'h4;

  typedef struct packed {
    logic [CH_COUNT-1:0][DATA_W-1:0] data;
    logic [CH_COUNT-1:0][HDR_W-1:0]  status;
  } acso_sample_t;

  typedef struct packed {
    logic       four_variant;
    logic       chain_enable;
    logic [1:0] format;
    logic [2:0] upstream;
  } acso_strap_t;

  typedef enum logic [2:0] {
    L_IDLE  = 3'b001,
    L_MARK  = 3'b010,
    L_SHIFT = 3'b100
  } acso_link_state_t;
endpackage
`default_nettype wire

/* hw/acso_lane_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module acso_lane_mem (
  input  wire logic                          clock,      // Link clock
  input  wire logic                          rst_b,      // Link reset, active low
  input  wire logic                          write_en,   // Word write strobe
  input  wire logic [acso_pkg::MEM_AW-1:0]   write_addr, // Word slot written
  input  wire logic [acso_pkg::WORD_W-1:0]   write_data, // Word from upstream
  input  wire logic [acso_pkg::MEM_AW-1:0]   read_addr,  // Word slot read
  output logic      [acso_pkg::WORD_W-1:0]   read_data   // Registered read word
);
  logic [acso_pkg::WORD_W-1:0] mem_array [acso_pkg::MEM_DEPTH];
  logic [acso_pkg::WORD_W-1:0] read_data_reg;

  always_ff @(posedge clock)
  begin
    if (write_en)
    begin
      mem_array[write_addr] <= write_data;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      read_data_reg <= 32'h0000_0000;
    end
    else
    begin
      read_data_reg <= mem_array[read_addr];
    end
  end

  assign read_data = read_data_reg;
endmodule
`default_nettype wire

/* testbench/acso_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module acso_properties (
  input wire logic       clock,                // Master clock
  input wire logic       rst_b,                // Reset, active low
  input wire logic       data_bit_clock,       // Link bit clock
  input wire logic       sample_valid,         // New sample set
  input wire logic       sync_command,         // Sync command pulse
  input wire logic       serial_control_mode,  // Serial control mode
  input wire logic       start_n,              // Start pin
  input wire logic       four_channel_variant, // Strap
  input wire logic       chain_enable,         // Strap
  input wire logic [1:0] output_format_select, // Strap
  input wire logic       sync_out_n,           // Sync out
  input wire logic       frame_ready_n,        // Frame marker
  input wire logic       serial_out_lane_b,    // Lane b
  input wire logic       chain_in_lane_a_o,    // Pin a drive value
  input wire logic       chain_in_lane_a_oe,   // Pin a enable
  input wire logic       chain_in_lane_b_o,    // Pin b drive value
  input wire logic       chain_in_lane_b_oe    // Pin b enable
);
  sequence s_pulse;
    !sync_out_n [*2] ##1 sync_out_n;
  endsequence
  sequence s_mark;
    !frame_ready_n ##1 frame_ready_n [*8];
  endsequence
  sync_len_a: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(sync_out_n) |-> s_pulse) else $error("sync out width wrong");
  start_sync_a: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(start_n) |-> ##[2:6] !sync_out_n) else $error("start gave no sync out");
  cmd_sync_a: assert property (@(posedge clock) disable iff (!rst_b)
    sync_command && serial_control_mode |-> ##[1:3] !sync_out_n) else $error("command lost");
  sync_quiet_a: assert property (@(posedge clock) disable iff (!rst_b)
    (start_n && !(sync_command && serial_control_mode)) [*8] |-> sync_out_n)
    else $error("sync out without cause");
  frame_start_a: assert property (@(posedge clock) disable iff (!rst_b)
    sample_valid |-> ##[1:12] !frame_ready_n) else $error("no frame marker");
  mark_len_a: assert property (@(posedge data_bit_clock) disable iff (!rst_b)
    $fell(frame_ready_n) |-> s_mark) else $error("frame marker width wrong");
  oe_pair_a: assert property (@(posedge data_bit_clock) disable iff (!rst_b)
    chain_in_lane_a_oe |-> chain_in_lane_b_oe && !chain_in_lane_a_o && !chain_in_lane_b_o)
    else $error("chain pins drive wrong");
  oe_off_a: assert property (@(posedge data_bit_clock) disable iff (!rst_b)
    (four_channel_variant || chain_enable) [*8] |-> !chain_in_lane_a_oe && !chain_in_lane_b_oe)
    else $error("chain pin driven while input");
  lane_b_quiet_a: assert property (@(posedge data_bit_clock) disable iff (!rst_b)
    (output_format_select[1] && !four_channel_variant) [*8] |-> !serial_out_lane_b)
    else $error("lane b active in single lane");
endmodule
bind acso_top acso_properties u_props (.clock, .rst_b, .data_bit_clock, .sample_valid,
  .sync_command, .serial_control_mode, .start_n, .four_channel_variant, .chain_enable,
  .output_format_select, .sync_out_n, .frame_ready_n, .serial_out_lane_b,
  .chain_in_lane_a_o, .chain_in_lane_a_oe, .chain_in_lane_b_o, .chain_in_lane_b_oe);
`default_nettype wire

/* testbench/acso_upstream_model.sv */
`timescale 1ns/10ps
`default_nettype none
module acso_upstream_model #(
  parameter logic [31:0] UP_A = 32'h9D3A61E5, // Upstream word, lane a
  parameter logic [31:0] UP_B = 32'h4C87B21F  // Upstream word, lane b
) (
  input  wire logic data_bit_clock, // Link clock
  input  wire logic rst_b,          // Reset, active low
  input  wire logic frame_ready_n,  // Shared frame marker
  output logic      lane_a,         // Upstream lane a
  output logic      lane_b,         // Upstream lane b
  output logic      dedicated       // Four-channel chain input
);
  logic [5:0] n_reg;
  assign dedicated = lane_a;
  // Sends one word per lane behind the marker, then a toggling released line
  always_ff @(posedge data_bit_clock or negedge rst_b)
    if (!rst_b)
    begin
      n_reg  <= 6'h20;
      lane_a <= 1'b0;
      lane_b <= 1'b0;
    end
    else if (!frame_ready_n)
    begin
      n_reg  <= 6'h01;
      lane_a <= UP_A[31];
      lane_b <= UP_B[31];
    end
    else if (n_reg < 6'h20)
    begin
      n_reg  <= n_reg + 6'h01;
      lane_a <= UP_A[5'h1F - n_reg[4:0]];
      lane_b <= UP_B[5'h1F - n_reg[4:0]];
    end
    else
    begin
      lane_a <= ~lane_a;
      lane_b <= ~lane_b;
    end
endmodule
`default_nettype wire

/* testbench/acso_top_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module acso_top_tb_top;
  localparam logic [31:0] UP_A = 32'h9D3A61E5;
  localparam logic [31:0] UP_B = 32'h4C87B21F;
  logic clock = 1'b0;
  logic data_bit_clock = 1'b0;
  logic rst_b, sample_valid, serial_control_mode, sync_command, start_n, sin_n;
  logic four_channel_variant, chain_enable, chain_in_dedicated, up_a, up_b;
  logic [1:0] crc_select, output_format_select;
  logic [2:0] chain_upstream_count;
  acso_pkg::acso_sample_t sample;
  logic sync_out_n, frame_overrun, frame_ready_n, serial_out_lane_a, serial_out_lane_b;
  logic chain_in_lane_a_o, chain_in_lane_a_oe, chain_in_lane_b_o, chain_in_lane_b_oe;
  wire logic sync_in_n;
  wire logic chain_in_lane_a_i;
  wire logic chain_in_lane_b_i;
  logic [511:0] cap_a, cap_b;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  // Sync out loops back to sync in, as in a chained system
  assign sync_in_n = sync_out_n & sin_n;
  assign chain_in_lane_a_i = chain_in_lane_a_oe ? chain_in_lane_a_o : up_a;
  assign chain_in_lane_b_i = chain_in_lane_b_oe ? chain_in_lane_b_o : up_b;
  always #12.5 clock = ~clock;
  always #15 data_bit_clock = ~data_bit_clock;
  acso_top uut (.clock, .rst_b, .data_bit_clock, .sample_valid, .sample, .serial_control_mode,
    .crc_select, .sync_command, .start_n, .sync_in_n, .four_channel_variant, .chain_enable,
    .output_format_select, .chain_upstream_count, .chain_in_dedicated, .chain_in_lane_a_i,
    .chain_in_lane_b_i, .sync_out_n, .frame_overrun, .frame_ready_n, .serial_out_lane_a,
    .serial_out_lane_b, .chain_in_lane_a_o, .chain_in_lane_a_oe, .chain_in_lane_b_o,
    .chain_in_lane_b_oe);
  acso_upstream_model #(.UP_A(UP_A), .UP_B(UP_B)) u_up (.data_bit_clock, .rst_b,
    .frame_ready_n, .lane_a(up_a), .lane_b(up_b), .dedicated(chain_in_dedicated));
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [23:0] dat(input int s, input int c);
    return {4'hC, c[3:0], s[7:0], 8'h3C};
  endfunction
  function automatic logic [7:0] stat(input int c);
    return {5'h08, c[2:0]};
  endfunction
  function automatic logic [31:0] wd(input logic [511:0] v, input int k, input int nb);
    return v[nb-1-32*k -: 32];
  endfunction
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [23:0] d);
    logic fb;
    for (int k = 23; k >= 0; k--)
    begin
      fb = d[k] ^ c[7];
      c = {c[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
    end
    return c;
  endfunction
  task automatic run_frame(input int s, input int nb);
    int i;
    @(posedge clock);
    for (i = 0; i < 8; i++)
    begin
      sample.data[i]   <= dat(s, i);
      sample.status[i] <= stat(i);
    end
    sample_valid <= 1'b1;
    @(posedge clock);
    sample_valid <= 1'b0;
    cap_a = '0;
    cap_b = '0;
    i = 0;
    while (frame_ready_n !== 1'b0 && i < 40)
    begin
      @(negedge data_bit_clock);
      i++;
    end
    chk(32'(i < 40), 32'h1);
    for (i = 0; i < nb; i++)
    begin
      @(negedge data_bit_clock);
      cap_a = {cap_a[510:0], serial_out_lane_a};
      cap_b = {cap_b[510:0], serial_out_lane_b};
    end
    repeat (8) @(posedge clock);
  endtask
  task automatic t_sync;
    int d, w;
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clock);
      serial_control_mode <= (k == 2);
      @(posedge clock);
      if (k == 0)
        start_n <= 1'b0;
      else
        sync_command <= 1'b1;
      @(posedge clock);
      start_n <= 1'b1;
      sync_command <= 1'b0;
      d = 0;
      while (sync_out_n !== 1'b0 && d < 10)
      begin
        @(negedge clock);
        d++;
      end
      chk(32'(d < 10), 32'(k != 1));
      w = 0;
      while (sync_out_n === 1'b0 && w < 10)
      begin
        @(negedge clock);
        w++;
      end
      if (k != 1)
        chk(32'(w), 32'(acso_pkg::SYNC_OUT_CYCLES));
      repeat (20) @(posedge clock);
    end
  endtask
  task automatic t_crc(input logic [1:0] sel, input int gl, input int n);
    logic [7:0] ca, cb, c1;
    logic       grp_end;
    run_frame(9, 128);
    @(posedge clock);
    crc_select <= sel;
    sin_n <= 1'b0;
    @(posedge clock);
    sin_n <= 1'b1;
    repeat (10) @(posedge clock);
    ca = acso_pkg::CRC_PRESET;
    cb = acso_pkg::CRC_PRESET;
    c1 = acso_pkg::CRC_PRESET;
    for (int s = 0; s < n; s++)
    begin
      run_frame(s, 128);
      grp_end = (s % gl == gl - 1);
      ca = crc8(ca, dat(s, 0));
      cb = crc8(cb, dat(s, 7));
      c1 = crc8(c1, dat(s, 1));
      chk(wd(cap_a, 0, 128), {grp_end ? ca : stat(0), dat(s, 0)});
      chk(wd(cap_b, 3, 128), {grp_end ? cb : stat(7), dat(s, 7)});
      chk(wd(cap_a, 1, 128), {grp_end ? c1 : stat(1), dat(s, 1)});
      if (grp_end)
      begin
        ca = acso_pkg::CRC_PRESET;
        cb = acso_pkg::CRC_PRESET;
        c1 = acso_pkg::CRC_PRESET;
      end
    end
  endtask
  task automatic t_lanes(input logic four, input logic chain, input logic [1:0] fmt,
                         input int w);
    int nb;
    nb = chain ? 64 * w : 32 * w;
    @(posedge clock);
    four_channel_variant <= four;
    chain_enable <= chain;
    output_format_select <= fmt;
    crc_select <= 2'h0;
    repeat (20) @(posedge clock);
    run_frame(20, nb);
    chk(wd(cap_a, w - 1, nb), {stat(w - 1), dat(20, w - 1)});
    if (chain)
      chk(wd(cap_a, w, nb), UP_A);
    if (!four && !fmt[1] && chain)
      chk(wd(cap_b, w, nb), UP_B);
    else if (four && !fmt[0] && !chain)
      chk(wd(cap_b, w - 1, nb), {stat(3), dat(20, 3)});
    else if (four || fmt[1])
      chk(32'(|cap_b), 32'h0);
    chk(32'({chain_in_lane_a_oe, chain_in_lane_b_oe}), 32'({2{!four && !chain}}));
  endtask
  task automatic t_overrun;
    @(posedge clock);
    sample_valid <= 1'b1;
    repeat (2) @(posedge clock);
    sample_valid <= 1'b0;
    @(negedge clock);
    chk(32'(frame_overrun), 32'h1);
    @(negedge clock);
    chk(32'(frame_overrun), 32'h0);
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  initial
  begin
    rst_b = 1'b0;
    {sample_valid, serial_control_mode, sync_command, four_channel_variant} = '0;
    {chain_enable, crc_select, sample} = '0;
    {start_n, sin_n} = 2'h3;
    output_format_select = 2'h1;
    chain_upstream_count = 3'h1;
    repeat (5) @(posedge clock);
    chk(32'({sync_out_n, frame_ready_n, serial_out_lane_a, chain_in_lane_a_oe}), 32'hC);
    rst_b <= 1'b1;
    repeat (5) @(posedge clock);
    t_sync();
    t_crc(acso_pkg::CRC_SEL_SHORT, 4, 8);
    t_crc(acso_pkg::CRC_SEL_LONG, 16, 16);
    t_lanes(1'b0, 1'b1, 2'h1, 4);
    t_lanes(1'b0, 1'b1, 2'h2, 8);
    t_lanes(1'b0, 1'b0, 2'h2, 8);
    t_lanes(1'b1, 1'b0, 2'h0, 2);
    t_lanes(1'b1, 1'b1, 2'h1, 4);
    t_overrun();
    wrap_up();
  end
endmodule
`default_nettype wire
